// [csdma_cpu.sv]
// Processor hold handshake model
`timescale 1ns/10ps
module csdma_cpu (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic hold_request,
	output logic hold_grant
);
	logic [3:0] lag_q = 4'h0;
	// Grant once the current cycle ends, release as soon as the request drops
	always_ff @(posedge sys_clk) begin
		if (!hold_request) begin
			lag_q <= 4'h0;
			hold_grant <= 1'b0;
		end else if (lag_q >= (slow ? 4'h6 : 4'h1)) begin
			hold_grant <= 1'b1;
		end else begin
			lag_q <= lag_q + 4'h1;
		end
	end
endmodule

// [csdma_fifo.sv]
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module csdma_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] fill_q;
	logic push;
	logic pop;
	// Honest full and empty from the fill count
	assign in_ready = (fill_q != (AW+1)'(DEPTH));
	assign out_valid = (fill_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];
	// Storage
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	// Pointers and fill
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wr_q <= AW'(wr_q + AW'(1));
			end
			if (pop) begin
				rd_q <= AW'(rd_q + AW'(1));
			end
			fill_q <= (AW+1)'(fill_q + (AW+1)'(push) - (AW+1)'(pop));
		end
	end
endmodule

// [csdma_params.svh]
// Constants for the cycle-steal DMA subsystem
`ifndef CSDMA_PARAMS_SVH
`define CSDMA_PARAMS_SVH
`define CSDMA_PORT_BASE 8'hf0
`define CSDMA_PORT_CH1_ADDR 8'hf2
`define CSDMA_PORT_CH1_CNT 8'hf3
`define CSDMA_PORT_MODE 8'hf8
`define CSDMA_PORT_LAST 8'hf7
`define CSDMA_CNT_BITS 14
`define CSDMA_DIR_HI 15
`define CSDMA_DIR_LO 14
`define CSDMA_MODE_AUTO 7
`define CSDMA_XTAL_KHZ 22032
`define CSDMA_CPU_KHZ 2448
`define CSDMA_SYS_KHZ 50000
`define CSDMA_REFRESH_NS 15500
`define CSDMA_XFER_CLOCKS 4
`define CSDMA_DIR_WRITE_MEM 2'h1
`define CSDMA_DIR_READ_MEM 2'h2
`endif

// [csdma_pkg.sv]
// Types for the cycle-steal DMA subsystem
package csdma_pkg;
	typedef enum logic [2:0] {
		CSDMA_IDLE = 3'h0,
		CSDMA_T1 = 3'h1,
		CSDMA_T2 = 3'h3,
		CSDMA_T3 = 3'h2,
		CSDMA_T4 = 3'h6
	} csdma_state_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [1:0] dir;
		logic [13:0] count;
	} csdma_chan_t;
	typedef struct packed {
		logic [7:0] port;
		logic [7:0] data;
	} csdma_pio_t;
	typedef struct packed {
		logic [1:0] chan;
		logic [15:0] addr;
	} csdma_xfer_t;
endpackage

// [csdma_top.sv]
// Four-channel cycle-steal DMA subsystem with bus command and reset logic
`timescale 1ns/10ps
`include "csdma_params.svh"
// Operation
// - Hold request gated by software DMA enable
// - One byte per four clocks, then release unless other work is pending at T4
// - Refresh request every 15.5 us, top priority
// - Channel 0 acknowledge then memory read
// - DMA active blocks all port decoding
// - Latch upper address byte during transfer
// - Auto-reload copies channel 3 into 2
// - Auto-reload only for channel 2, reloaded from channel 3
// - Channel 1 via address, count, mode ports
// - Mode port read returns all-channel status
// - Reset disables all channels
// - Wait fed to ready: one wait state
// - Read strobes immediate, writes await strobe
// - Divide 50 MHz system clock by 20 for 2.5 MHz processor clock enable
// - Both resets drive board init signal
// - Panel reset spares display and timer
// - Count word top bits select direction
// - Terminal count sets channel completion status
// - Channel 3 is storage only
module csdma_top #(
	parameter int REFRESH_CYCLES = (`CSDMA_REFRESH_NS * `CSDMA_SYS_KHZ) / 1000000,
	parameter int CPU_DIV = `CSDMA_SYS_KHZ / `CSDMA_CPU_KHZ,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic power_on_rst,
	input wire logic panel_rst_n,
	input wire logic [7:0] port_addr,
	input wire logic [7:0] port_wdata,
	input wire logic port_wr,
	input wire logic port_rd,
	output logic [7:0] port_rdata,
	input wire logic cpu_wr_strobe,
	input wire logic cpu_mem_cycle,
	input wire logic cpu_rd_cycle,
	input wire logic cpu_status_valid,
	input wire logic cpu_wait,
	output logic cpu_ready,
	input wire logic dma_gate,
	input wire logic [2:1] dev_req,
	input wire logic hold_grant,
	output logic hold_request,
	output logic dma_active,
	output logic [3:0] dma_ack_n,
	output logic mem_read_n,
	output logic mem_write_n,
	output logic io_read_n,
	output logic io_write_n,
	output logic cycle_status_strobe,
	output logic io_decode_en,
	output logic [7:0] addr_hi_latch,
	output logic [7:0] addr_lo,
	output logic board_init_n,
	output logic periph_reset,
	output logic cpu_clk_en,
	output logic [17:0] xfer_data,
	output logic xfer_valid,
	input wire logic xfer_ready
);
	localparam int XFER_W = 18;
	csdma_pkg::csdma_chan_t chan_q [4];
	csdma_pkg::csdma_state_t state_q;
	csdma_pkg::csdma_pio_t pio;
	csdma_pkg::csdma_xfer_t cur_q;
	logic [7:0] mode_q;
	logic [3:0] done_q;
	logic [3:0] flip_q;
	logic [15:0] tmr_q;
	logic [7:0] div_q;
	logic ref_req_q;
	logic grant_s1_q, grant_s2_q, req_s1_q, req_s2_q, req2_s1_q, req2_s2_q;
	logic pr_s1_q, pr_s2_q, pp_s1_q, pp_s2_q;
	logic [3:0] req;
	logic [1:0] win;
	logic any_req;
	logic fifo_in_ready;
	logic last_byte;
	logic pending;
	logic [1:0] hold_hist_q;
	// Input synchronisers for pins from outside the clock domain
	always_ff @(posedge sys_clk) begin
		grant_s1_q <= hold_grant;
		grant_s2_q <= grant_s1_q;
		req_s1_q <= dev_req[1];
		req_s2_q <= req_s1_q;
		req2_s1_q <= dev_req[2];
		req2_s2_q <= req2_s1_q;
		pr_s1_q <= power_on_rst;
		pr_s2_q <= pr_s1_q;
		pp_s1_q <= ~panel_rst_n;
		pp_s2_q <= pp_s1_q;
	end
	assign pio = '{port: port_addr, data: port_wdata};
	// Board init from either reset, display/timer reset on power-on only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			board_init_n <= 1'b0;
			periph_reset <= 1'b1;
		end else begin
			board_init_n <= ~(pr_s2_q | pp_s2_q);
			periph_reset <= pr_s2_q;
		end
	end
	// Processor clock enable divided from the system clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_q <= '0;
			cpu_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= (div_q == 8'(CPU_DIV - 1));
			div_q <= (div_q == 8'(CPU_DIV - 1)) ? 8'h00 : 8'(div_q + 8'h01);
		end
	end
	// Refresh timer raising channel 0 request
	always_ff @(posedge sys_clk) begin
		if (rst || ~board_init_n && pr_s2_q) begin
			tmr_q <= '0;
			ref_req_q <= 1'b0;
		end else begin
			if (tmr_q == 16'(REFRESH_CYCLES - 1)) begin
				tmr_q <= '0;
				ref_req_q <= 1'b1;
			end else begin
				tmr_q <= 16'(tmr_q + 16'h0001);
			end
			if (state_q == csdma_pkg::CSDMA_T4 && cur_q.chan == 2'h0) begin
				ref_req_q <= 1'b0;
			end
		end
	end
	// Requests qualified by channel enables; channel 3 never requests
	assign req = {1'b0, req2_s2_q & mode_q[2], req_s2_q & mode_q[1], ref_req_q & mode_q[0]};
	assign any_req = |req;
	// Fixed priority encoder
	always_comb begin
		win = 2'h3;
		if (req[0]) begin
			win = 2'h0;
		end else if (req[1]) begin
			win = 2'h1;
		end else if (req[2]) begin
			win = 2'h2;
		end
	end
	// Work still waiting at T4 keeps the bus; the refresh just served does not count
	assign pending = (|req[3:1]) || (req[0] && cur_q.chan != 2'h0);
	// Hold request gated by the software DMA enable; no bus asked for from idle while the FIFO is full
	assign hold_request = dma_gate && (
		(state_q == csdma_pkg::CSDMA_IDLE && any_req && fifo_in_ready) ||
		(state_q != csdma_pkg::CSDMA_IDLE && (state_q != csdma_pkg::CSDMA_T4 || pending)));
	assign dma_active = (state_q != csdma_pkg::CSDMA_IDLE);
	assign io_decode_en = ~dma_active;
	assign cpu_ready = ~cpu_wait;
	assign last_byte = (chan_q[cur_q.chan].count == '0);
	// Hold history: a synchronised grant is stale unless hold stood through the sync delay
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_hist_q <= 2'h0;
		end else begin
			hold_hist_q <= {hold_hist_q[0], hold_request};
		end
	end
	// Four-clock transfer sequencer; it waits in idle, never mid-cycle, while the FIFO is full
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= csdma_pkg::CSDMA_IDLE;
			cur_q <= '0;
		end else begin
			case (state_q)
				csdma_pkg::CSDMA_IDLE: begin
					if (hold_request && grant_s2_q && hold_hist_q == 2'h3) begin
						state_q <= csdma_pkg::CSDMA_T1;
						cur_q <= '{chan: win, addr: chan_q[win].addr};
					end
				end
				csdma_pkg::CSDMA_T1: state_q <= csdma_pkg::CSDMA_T2;
				csdma_pkg::CSDMA_T2: state_q <= csdma_pkg::CSDMA_T3;
				csdma_pkg::CSDMA_T3: state_q <= csdma_pkg::CSDMA_T4;
				csdma_pkg::CSDMA_T4: state_q <= csdma_pkg::CSDMA_IDLE;
				default: state_q <= csdma_pkg::CSDMA_IDLE;
			endcase
		end
	end
	// Upper address byte latch and low address lines
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_hi_latch <= '0;
			addr_lo <= '0;
		end else if (state_q == csdma_pkg::CSDMA_T1) begin
			addr_hi_latch <= cur_q.addr[15:8];
			addr_lo <= cur_q.addr[7:0];
		end
	end
	// Acknowledge and strobes; direction from the count word, refresh reads memory
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dma_ack_n <= 4'hf;
			mem_read_n <= 1'b1;
			mem_write_n <= 1'b1;
			io_read_n <= 1'b1;
			io_write_n <= 1'b1;
			cycle_status_strobe <= 1'b0;
		end else if (dma_active) begin
			cycle_status_strobe <= 1'b0;
			dma_ack_n <= 4'hf;
			mem_read_n <= 1'b1;
			mem_write_n <= 1'b1;
			io_read_n <= 1'b1;
			io_write_n <= 1'b1;
			if (state_q == csdma_pkg::CSDMA_T2 || state_q == csdma_pkg::CSDMA_T3) begin
				dma_ack_n[cur_q.chan] <= 1'b0;
				if (state_q == csdma_pkg::CSDMA_T3) begin
					if (cur_q.chan == 2'h0 ||
						chan_q[cur_q.chan].dir == `CSDMA_DIR_READ_MEM) begin
						mem_read_n <= 1'b0;
						io_write_n <= (cur_q.chan == 2'h0);
					end else if (chan_q[cur_q.chan].dir == `CSDMA_DIR_WRITE_MEM) begin
						mem_write_n <= 1'b0;
						io_read_n <= 1'b0;
					end
				end
			end
		end else begin
			// Processor bus commands: reads at once, writes wait for the strobe
			dma_ack_n <= 4'hf;
			cycle_status_strobe <= cpu_status_valid;
			mem_read_n <= ~(cpu_status_valid && cpu_rd_cycle && cpu_mem_cycle);
			io_read_n <= ~(cpu_status_valid && cpu_rd_cycle && !cpu_mem_cycle);
			mem_write_n <= ~(!cpu_rd_cycle && cpu_wr_strobe && cpu_mem_cycle);
			io_write_n <= ~(!cpu_rd_cycle && cpu_wr_strobe && !cpu_mem_cycle);
		end
	end
	// Channel registers, mode, and completion flags
	always_ff @(posedge sys_clk) begin
		if (rst || !board_init_n) begin
			mode_q <= 8'h00;
			done_q <= '0;
			flip_q <= '0;
			for (int i = 0; i < 4; i++) begin
				chan_q[i] <= '0;
			end
		end else begin
			if (port_wr && pio.port >= `CSDMA_PORT_BASE && pio.port <= `CSDMA_PORT_LAST
				&& !dma_active) begin
				flip_q[pio.port[2:1]] <= ~flip_q[pio.port[2:1]];
				if (!pio.port[0]) begin
					if (flip_q[pio.port[2:1]]) begin
						chan_q[pio.port[2:1]].addr[15:8] <= pio.data;
					end else begin
						chan_q[pio.port[2:1]].addr[7:0] <= pio.data;
					end
				end else if (flip_q[pio.port[2:1]]) begin
					chan_q[pio.port[2:1]].dir <= pio.data[7:6];
					chan_q[pio.port[2:1]].count[13:8] <= pio.data[5:0];
				end else begin
					chan_q[pio.port[2:1]].count[7:0] <= pio.data;
				end
			end
			if (port_wr && pio.port == `CSDMA_PORT_MODE && !dma_active) begin
				mode_q <= pio.data;
				flip_q <= '0;
			end
			if (port_rd && pio.port == `CSDMA_PORT_MODE && !dma_active) begin
				done_q <= '0; // Status read clears completion flags
			end
			// Address advance and count down at end of each non-refresh cycle
			if (state_q == csdma_pkg::CSDMA_T4 && cur_q.chan != 2'h0) begin
				chan_q[cur_q.chan].addr <= 16'(chan_q[cur_q.chan].addr + 16'h0001);
				chan_q[cur_q.chan].count <= 14'(chan_q[cur_q.chan].count - 14'h0001);
				if (last_byte) begin
					done_q[cur_q.chan] <= 1'b1;
					mode_q[cur_q.chan] <= (cur_q.chan == 2'h2) && mode_q[`CSDMA_MODE_AUTO];
					if (cur_q.chan == 2'h2 && mode_q[`CSDMA_MODE_AUTO]) begin
						chan_q[2] <= chan_q[3];
					end
				end
			end
		end
	end
	// Status byte: completion flags of all channels
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_rdata <= '0;
		end else if (port_rd && pio.port == `CSDMA_PORT_MODE && !dma_active) begin
			port_rdata <= {4'h0, done_q};
		end
	end
	// Transfer log buffered for the downstream consumer
	csdma_fifo #(.WIDTH(XFER_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_data(cur_q),
		.in_valid(state_q == csdma_pkg::CSDMA_T1),
		.in_ready(fifo_in_ready),
		.out_data(xfer_data),
		.out_valid(xfer_valid),
		.out_ready(xfer_ready)
	);
endmodule

// [csdma_top_chk.sv]
// Port assertions for the DMA subsystem
`timescale 1ns/10ps
module csdma_top_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic power_on_rst,
	input wire logic panel_rst_n,
	input wire logic cpu_wait,
	input wire logic cpu_ready,
	input wire logic dma_gate,
	input wire logic hold_request,
	input wire logic dma_active,
	input wire logic io_decode_en,
	input wire logic [3:0] dma_ack_n,
	input wire logic mem_read_n,
	input wire logic periph_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Bus ownership and cycle shape
	gate_hold_a: assert property (hold_request |-> dma_gate)
		else $error("hold without gate");
	one_byte_a: assert property ($rose(dma_active) |-> dma_active[*4] ##1 !dma_active)
		else $error("cycle length");
	refresh_seq_a: assert property ($fell(dma_ack_n[0]) |=> !mem_read_n)
		else $error("refresh strobe");
	decode_off_a: assert property (dma_active |-> !io_decode_en)
		else $error("decode during dma");
	ch3_idle_a: assert property (dma_ack_n[3])
		else $error("channel 3 ack");
	wait_ready_a: assert property (cpu_ready == !cpu_wait)
		else $error("ready loop");
	one_ack_a: assert property ($countones(~dma_ack_n) <= 1)
		else $error("two acks");
	panel_spare_a: assert property (!panel_rst_n && !power_on_rst && !$past(power_on_rst)
		&& !periph_reset |=> !periph_reset)
		else $error("panel reset hit display");
endmodule
bind csdma_top csdma_top_chk u_chk (.sys_clk, .rst, .power_on_rst, .panel_rst_n, .cpu_wait,
	.cpu_ready, .dma_gate, .hold_request, .dma_active, .io_decode_en, .dma_ack_n, .mem_read_n,
	.periph_reset);

// [csdma_top_tb.sv]
// Self-checking testbench for the DMA subsystem
`timescale 1ns/10ps
module csdma_top_tb;
	logic sys_clk, rst, power_on_rst, panel_rst_n, port_wr, port_rd, cpu_wait, dma_gate;
	logic cpu_wr_strobe, cpu_mem_cycle, cpu_rd_cycle, cpu_status_valid, cpu_ready, cpu_clk_en;
	logic io_read_n, io_write_n, cycle_status_strobe, io_decode_en;
	logic hold_grant, hold_request, dma_active, mem_read_n, mem_write_n, slow;
	logic board_init_n, periph_reset, xfer_valid, xfer_ready;
	logic [7:0] port_addr, port_wdata, port_rdata, addr_hi_latch, hi_seen, addr_lo, lo_seen;
	logic [2:1] dev_req;
	logic [3:0] dma_ack_n;
	logic [17:0] xfer_data;
	logic [17:0] q[$];
	int n_mismatch, check_count, cyc, n_hold, n_ack0, n_dir, n_clk, k0;
	csdma_top #(.REFRESH_CYCLES(20)) dut (.sys_clk, .rst, .power_on_rst, .panel_rst_n,
		.port_addr, .port_wdata, .port_wr, .port_rd, .port_rdata, .cpu_wr_strobe,
		.cpu_mem_cycle, .cpu_rd_cycle, .cpu_status_valid, .cpu_wait,
		.cpu_ready, .dma_gate, .dev_req, .hold_grant, .hold_request, .dma_active,
		.dma_ack_n, .mem_read_n, .mem_write_n, .io_read_n, .io_write_n,
		.cycle_status_strobe, .io_decode_en, .addr_hi_latch, .addr_lo, .board_init_n,
		.periph_reset, .cpu_clk_en, .xfer_data, .xfer_valid, .xfer_ready);
	csdma_cpu cpu (.sys_clk, .slow, .hold_request, .hold_grant);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Watch bus activity and log popped transfers
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (hold_request) n_hold <= n_hold + 1;
		if (!dma_ack_n[0]) n_ack0 <= n_ack0 + 1;
		if (!dma_ack_n[1]) {hi_seen, lo_seen} <= {addr_hi_latch, addr_lo};
		if (cpu_clk_en) n_clk <= n_clk + 1;
		if (!dma_ack_n[1] && !mem_write_n || !dma_ack_n[2] && !mem_read_n) n_dir <= n_dir + 1;
		if (xfer_valid && xfer_ready) q.push_back(xfer_data);
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	always @(negedge sys_clk) cpu_wait <= ~cpu_wait;
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One port access, offered only when the DMA unit does not own the bus
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		while (dma_active) @(negedge sys_clk);
		port_addr = a;
		port_wdata = d;
		port_wr = !r;
		port_rd = r;
		@(negedge sys_clk);
		port_wr = 1'b0;
		port_rd = 1'b0;
		@(negedge sys_clk);
	endtask
	function automatic int cnt(input logic [1:0] c);
		cnt = 0;
		foreach (q[i]) if (q[i][17:16] == c) cnt++;
	endfunction
	function automatic logic [15:0] nth(input logic [1:0] c, input int k);
		nth = 16'h0000;
		foreach (q[i]) if (q[i][17:16] == c) begin
			if (k == 0) return q[i][15:0];
			k--;
		end
	endfunction
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{rst, panel_rst_n, xfer_ready} = 3'h7;
		{power_on_rst, port_wr, port_rd, cpu_wait, dma_gate, slow} = 6'h00;
		{port_addr, port_wdata, dev_req} = 18'h00000;
		{cpu_wr_strobe, cpu_mem_cycle, cpu_rd_cycle, cpu_status_valid} = 4'h0;
		{cyc, n_hold, n_ack0, n_dir, n_mismatch, check_count, n_clk, k0} = '0;
		wt(3);
		rst = 1'b0;
		while (!board_init_n) @(negedge sys_clk);
		acc(1'b1, 8'hf8, 8'h00);
		check(port_rdata, 8'h00);
		$display("reset test done");
		{cpu_status_valid, cpu_rd_cycle, cpu_mem_cycle} = 3'h7;
		wt(1);
		check(mem_read_n, 1'b0);
		check(cycle_status_strobe, 1'b1);
		check(io_decode_en, 1'b1);
		check(cpu_ready, !cpu_wait);
		{cpu_rd_cycle, cpu_mem_cycle} = 2'h0;
		wt(1);
		check(io_read_n, 1'b1);
		check(io_write_n, 1'b1);
		cpu_wr_strobe = 1'b1;
		wt(1);
		check(io_write_n, 1'b0);
		{cpu_wr_strobe, cpu_status_valid} = 2'h0;
		k0 = n_clk;
		wt(200);
		check(io_write_n, 1'b1);
		check(n_clk - k0, 10);
		$display("bus command test done");
		acc(1'b0, 8'hf8, 8'h01);
		wt(60);
		check(n_hold, 0);
		dma_gate = 1'b1;
		wt(60);
		check(n_ack0 != 0, 1'b1);
		$display("gate test done");
		q.delete();
		acc(1'b0, 8'hf2, 8'h34);
		acc(1'b0, 8'hf2, 8'h12);
		acc(1'b0, 8'hf3, 8'h02);
		acc(1'b0, 8'hf3, 8'h40);
		acc(1'b0, 8'hf8, 8'h03);
		dev_req[1] = 1'b1;
		while (cnt(2'h1) < 3) @(negedge sys_clk);
		wt(60);
		dev_req[1] = 1'b0;
		check(cnt(2'h1), 3);
		check(nth(2'h1, 0), 16'h1234);
		check(nth(2'h1, 2), 16'h1236);
		check(hi_seen, 8'h12);
		check(lo_seen, 8'h36);
		check(n_dir != 0, 1'b1);
		acc(1'b1, 8'hf8, 8'h00);
		check(port_rdata, 8'h02);
		acc(1'b1, 8'hf8, 8'h00);
		check(port_rdata, 8'h00);
		$display("disk test done");
		q.delete();
		n_dir = 0;
		slow = 1'b1;
		acc(1'b0, 8'hf4, 8'h00);
		acc(1'b0, 8'hf4, 8'h01);
		acc(1'b0, 8'hf5, 8'h00);
		acc(1'b0, 8'hf5, 8'h80);
		acc(1'b0, 8'hf6, 8'h00);
		acc(1'b0, 8'hf6, 8'h02);
		acc(1'b0, 8'hf7, 8'h01);
		acc(1'b0, 8'hf7, 8'h80);
		acc(1'b0, 8'hf8, 8'h85);
		dev_req[2] = 1'b1;
		while (cnt(2'h2) < 2) @(negedge sys_clk);
		dev_req[2] = 1'b0;
		check(nth(2'h2, 0), 16'h0100);
		check(nth(2'h2, 1), 16'h0200);
		check(cnt(2'h1) + cnt(2'h3), 0);
		check(n_dir != 0, 1'b1);
		$display("reload test done");
		wt(20);
		q.delete();
		slow = 1'b0;
		xfer_ready = 1'b0;
		acc(1'b0, 8'hf8, 8'h01);
		wt(600);
		check(xfer_valid, 1'b1);
		xfer_ready = 1'b1;
		wt(16);
		check(q.size(), 16);
		$display("buffer test done");
		panel_rst_n = 1'b0;
		wt(6);
		check(periph_reset, 1'b0);
		check(board_init_n, 1'b0);
		{panel_rst_n, power_on_rst} = 2'h3;
		wt(6);
		check(periph_reset, 1'b1);
		power_on_rst = 1'b0;
		wt(12);
		k0 = n_ack0;
		wt(60);
		check(n_ack0 - k0, 0);
		acc(1'b1, 8'hf8, 8'h00);
		check(port_rdata, 8'h00);
		$display("init test done");
		conclude();
	end
endmodule
